// [src/flash_id_secreg.sv]
// serial flash identification reads and security-area erase decoder
`timescale 1ns/100ps
`default_nettype none
`include "flash_id_consts.svh"

// Operation
// - 90h, zero address, mfr/dev codes single
// - 92h, two bits per clock in and out
// - 94h, four dummy clocks, quad in/out
// - multi-wire ids repeat until chip select
// - 4Bh, four dummy bytes, 64-bit number
// - 9Fh returns maker, type, capacity bytes
// - 5Ah, address, eight dummies, then table
// - three independent 256-byte security areas
// - erase only with write latch set
// - area select in A15-A12, rest zero; A7-A0 are not checked
// - chip select must rise after 24th bit
// - erase busy while self-timed cycle runs
// - write latch cleared when erase completes
// - lock bit set forbids that area's erase
module flash_id_secreg #(
	parameter int unsigned erase_cycles = 50000,
	parameter logic [7:0] mfr_code = 8'h5C, // arbitrary value
	parameter logic [7:0] device_code = 8'h11, // arbitrary value
	parameter logic [7:0] mem_type = 8'h22, // arbitrary value
	parameter logic [7:0] capacity = 8'h33, // arbitrary value
	parameter logic [63:0] unique_id = 64'h0123_4567_89AB_CDEF // arbitrary
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic wel_set,
	input wire logic [2:0] lock_set,
	input wire logic table_wr_en,
	input wire logic [7:0] table_wr_addr,
	input wire logic [7:0] table_wr_data,
	output logic write_latch_flag,
	output logic [2:0] area_lock_bits,
	output logic busy,
	output logic erase_pulse,
	output logic [1:0] erase_area
);

	logic cs_s1_q, cs_s2_q, cs_s3_q;
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic [3:0] io_s1_q, io_s2_q;
	logic sclk_rise, sclk_fall, cs_rise, deselected;

	flash_id_pkg::state_type state_q;
	flash_id_pkg::lane_type in_lane_q, out_lane_q;
	logic [7:0] op_q;
	logic [7:0] op_next;
	logic [5:0] cnt_q;
	logic [5:0] need_q;
	logic [31:0] sh_q;
	logic [31:0] sh_next;
	logic [23:0] erase_addr_q;
	logic [7:0] tbl_addr_q;
	logic [7:0] tbl_rd_data;

	logic [63:0] word_q;
	logic [63:0] fresh;
	logic [63:0] cur;
	logic [6:0] len;
	logic [6:0] out_cnt_q;
	logic [6:0] step;

	logic [31:0] erase_cnt_q;
	logic area_ok;
	logic [3:0] area_sel;

	// link pins cross into clk through two stages; edges use later stages
	always_ff @(posedge clk) begin
		if (reset) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			io_s1_q <= 4'h0;
			io_s2_q <= 4'h0;
		end else begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			sclk_s1_q <= sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			io_s1_q <= io_in;
			io_s2_q <= io_s1_q;
		end
	end

	assign deselected = cs_s2_q;
	assign sclk_rise = sclk_s2_q & ~sclk_s3_q & ~cs_s2_q;
	assign sclk_fall = ~sclk_s2_q & sclk_s3_q & ~cs_s2_q;
	assign cs_rise = cs_s2_q & ~cs_s3_q;

	assign op_next = {op_q[6:0], io_s2_q[0]};

	// address bits enter on the lanes of the current command
	always_comb begin
		case (in_lane_q)
		flash_id_pkg::lane_quad: sh_next = {sh_q[27:0], io_s2_q};
		flash_id_pkg::lane_dual: sh_next = {sh_q[29:0], io_s2_q[1:0]};
		default: sh_next = {sh_q[30:0], io_s2_q[0]};
		endcase
	end

	// command decoder, sampled on rising link clock
	always_ff @(posedge clk) begin
		if (reset || deselected) begin
			state_q <= flash_id_pkg::st_cmd;
			cnt_q <= 6'd0;
			need_q <= 6'd0;
			op_q <= 8'h00;
			sh_q <= 32'h0000_0000;
			in_lane_q <= flash_id_pkg::lane_single;
			out_lane_q <= flash_id_pkg::lane_single;
		end else if (sclk_rise) begin
			case (state_q)
			flash_id_pkg::st_cmd: begin
				op_q <= op_next;
				cnt_q <= cnt_q + 6'd1;
				if (cnt_q == `OPCODE_CLOCKS - 6'd1) begin
					cnt_q <= 6'd0;
					state_q <= flash_id_pkg::st_addr;
					in_lane_q <= flash_id_pkg::lane_single;
					out_lane_q <= flash_id_pkg::lane_single;
					if (busy) begin
						state_q <= flash_id_pkg::st_skip;
					end else begin
						case (op_next)
						`OP_MFR_ID_SINGLE: need_q <= `ADDR_CLOCKS_SINGLE;
						`OP_MFR_ID_DUAL: begin
							need_q <= `ADDR_CLOCKS_DUAL;
							in_lane_q <= flash_id_pkg::lane_dual;
							out_lane_q <= flash_id_pkg::lane_dual;
						end
						`OP_MFR_ID_QUAD: begin
							need_q <= `ADDR_CLOCKS_QUAD;
							in_lane_q <= flash_id_pkg::lane_quad;
							out_lane_q <= flash_id_pkg::lane_quad;
						end
						`OP_UNIQUE_ID: need_q <= `DUMMY_CLOCKS_UID;
						`OP_PARAM_TABLE: need_q <= `ADDR_DUMMY_CLOCKS_TABLE;
						`OP_AREA_ERASE: need_q <= `ADDR_CLOCKS_SINGLE;
						`OP_STD_ID: state_q <= flash_id_pkg::st_data;
						default: state_q <= flash_id_pkg::st_skip;
						endcase
					end
				end
			end
			flash_id_pkg::st_addr: begin
				// dual/quad address and mode byte are counted, not checked
				sh_q <= sh_next;
				cnt_q <= cnt_q + 6'd1;
				if (cnt_q == need_q - 6'd1) begin
					if (op_q == `OP_AREA_ERASE) begin
						state_q <= flash_id_pkg::st_armed;
					end else begin
						state_q <= flash_id_pkg::st_data;
					end
				end
			end
			// an extra clock after the last address bit cancels the erase
			flash_id_pkg::st_armed: state_q <= flash_id_pkg::st_skip;
			default: state_q <= state_q;
			endcase
		end
	end

	// start byte of the table and the erase target, caught at the last address or dummy clock
	always_ff @(posedge clk) begin
		if (reset) begin
			tbl_addr_q <= 8'h00;
			erase_addr_q <= 24'h00_0000;
		end else if (sclk_rise && state_q == flash_id_pkg::st_addr &&
				cnt_q == need_q - 6'd1) begin
			tbl_addr_q <= sh_next[15:8];
			erase_addr_q <= sh_next[23:0];
		end else if (sclk_fall && state_q == flash_id_pkg::st_data &&
				out_cnt_q == 7'd0 && op_q == `OP_PARAM_TABLE) begin
			tbl_addr_q <= tbl_addr_q + 8'h01; // wraps within the table
		end
	end

	param_table_mem #(
		.addr_width(8),
		.data_width(8)
	) table_mem (
		.clk(clk),
		.wr_en(table_wr_en),
		.wr_addr(table_wr_addr),
		.wr_data(table_wr_data),
		.rd_addr(tbl_addr_q),
		.rd_data(tbl_rd_data)
	);

	// next pattern; the table read has several clk cycles before the fall
	always_comb begin
		case (op_q)
		`OP_STD_ID: begin
			fresh = {mfr_code, mem_type, capacity, 40'h00_0000_0000};
			len = `LEN_STD_ID;
		end
		`OP_UNIQUE_ID: begin
			fresh = unique_id;
			len = `LEN_UID;
		end
		`OP_PARAM_TABLE: begin
			fresh = {tbl_rd_data, 56'h00_0000_0000_0000};
			len = `LEN_TABLE_BYTE;
		end
		default: begin
			fresh = {mfr_code, device_code, 48'h0000_0000_0000};
			len = `LEN_MFR_DEV;
		end
		endcase
		case (out_lane_q)
		flash_id_pkg::lane_quad: step = 7'd4;
		flash_id_pkg::lane_dual: step = 7'd2;
		default: step = 7'd1;
		endcase
		cur = (out_cnt_q == 7'd0) ? fresh : word_q;
	end

	// output shifter, driven on the falling link clock; patterns repeat
	always_ff @(posedge clk) begin
		if (reset || deselected) begin
			word_q <= 64'h0000_0000_0000_0000;
			out_cnt_q <= 7'd0;
			io_out <= 4'h0;
			io_oe <= `OE_NONE;
		end else if (sclk_fall && state_q == flash_id_pkg::st_data) begin
			word_q <= cur << step;
			out_cnt_q <= ((out_cnt_q == 7'd0) ? len : out_cnt_q) - step;
			case (out_lane_q)
			flash_id_pkg::lane_quad: begin
				io_out <= cur[63:60];
				io_oe <= `OE_QUAD;
			end
			flash_id_pkg::lane_dual: begin
				io_out <= {2'b00, cur[63:62]};
				io_oe <= `OE_DUAL;
			end
			default: begin
				io_out <= {2'b00, cur[63], 1'b0};
				io_oe <= `OE_SINGLE;
			end
			endcase
		end
	end

	assign area_sel = erase_addr_q[15:12];
	assign area_ok = (erase_addr_q[23:16] == `AREA_HIGH_ZERO) &&
		(erase_addr_q[11:8] == `AREA_MID_ZERO) &&
		(area_sel >= `AREA_SEL_FIRST) && (area_sel <= `AREA_SEL_LAST);

	// lock bits only ever gain ones; reset clears the local copy
	always_ff @(posedge clk) begin
		if (reset) begin
			area_lock_bits <= 3'b000;
		end else begin
			area_lock_bits <= area_lock_bits | lock_set;
		end
	end

	// self-timed erase of one area
	always_ff @(posedge clk) begin
		if (reset) begin
			busy <= 1'b0;
			erase_cnt_q <= 32'h0000_0000;
			erase_pulse <= 1'b0;
			erase_area <= 2'b00;
		end else begin
			erase_pulse <= 1'b0;
			if (busy) begin
				erase_cnt_q <= erase_cnt_q - 32'h0000_0001;
				if (erase_cnt_q == 32'h0000_0000) begin
					busy <= 1'b0;
				end
			end else if (cs_rise && state_q == flash_id_pkg::st_armed &&
					write_latch_flag && area_ok &&
					!area_lock_bits[area_sel[1:0] - 2'd1]) begin
				busy <= 1'b1;
				erase_cnt_q <= erase_cycles - 32'h0000_0001;
				erase_pulse <= 1'b1;
				erase_area <= area_sel[1:0];
			end
		end
	end

	// write latch: a set in the finishing cycle wins over the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			write_latch_flag <= 1'b0;
		end else if (wel_set) begin
			write_latch_flag <= 1'b1;
		end else if (busy && erase_cnt_q == 32'h0000_0000) begin
			write_latch_flag <= 1'b0;
		end
	end

endmodule // flash_id_secreg

`default_nettype wire

// [src/flash_id_consts.svh]
// constants for the identification and security-area erase decoder
`ifndef FLASH_ID_CONSTS_SVH
`define FLASH_ID_CONSTS_SVH

`define OP_MFR_ID_SINGLE 8'h90
`define OP_MFR_ID_DUAL 8'h92
`define OP_MFR_ID_QUAD 8'h94
`define OP_UNIQUE_ID 8'h4B
`define OP_STD_ID 8'h9F
`define OP_PARAM_TABLE 8'h5A
`define OP_AREA_ERASE 8'h44

`define OPCODE_CLOCKS 6'd8
`define ADDR_CLOCKS_SINGLE 6'd24
`define ADDR_CLOCKS_DUAL 6'd16
`define ADDR_CLOCKS_QUAD 6'd12
`define DUMMY_CLOCKS_UID 6'd32
`define ADDR_DUMMY_CLOCKS_TABLE 6'd32

`define LEN_MFR_DEV 7'd16
`define LEN_STD_ID 7'd24
`define LEN_UID 7'd64
`define LEN_TABLE_BYTE 7'd8

`define AREA_HIGH_ZERO 8'h00
`define AREA_MID_ZERO 4'h0
`define AREA_SEL_FIRST 4'h1
`define AREA_SEL_LAST 4'h3

`define OE_SINGLE 4'h2
`define OE_DUAL 4'h3
`define OE_QUAD 4'hF
`define OE_NONE 4'h0

`endif

// [src/flash_id_pkg.sv]
// types for the identification and security-area erase decoder
package flash_id_pkg;

	typedef enum logic [2:0] {
		st_cmd = 3'h0,
		st_addr = 3'h1,
		st_data = 3'h3,
		st_armed = 3'h2,
		st_skip = 3'h6
	} state_type;

	typedef enum logic [1:0] {
		lane_single = 2'h0,
		lane_dual = 2'h1,
		lane_quad = 2'h2
	} lane_type;

endpackage

// [src/param_table_mem.sv]
// parameter table storage with registered read data
`timescale 1ns/100ps
`default_nettype none

module param_table_mem #(
	parameter int addr_width = 8,
	parameter int data_width = 8
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [addr_width-1:0] wr_addr,
	input wire logic [data_width-1:0] wr_data,
	input wire logic [addr_width-1:0] rd_addr,
	output logic [data_width-1:0] rd_data
);

	logic [data_width-1:0] mem [0:(1<<addr_width)-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // param_table_mem

`default_nettype wire

// [verif/flash_id_props.sv]
// assertions on the decoder's status and lane-enable ports
`timescale 1ns/100ps
`default_nettype none
module flash_id_props #(
	parameter int unsigned erase_cycles = 50000
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic [3:0] io_oe,
	input wire logic wel_set,
	input wire logic [2:0] lock_set,
	input wire logic write_latch_flag,
	input wire logic [2:0] area_lock_bits,
	input wire logic busy,
	input wire logic erase_pulse,
	input wire logic [1:0] erase_area
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// busy length too long for a repetition, so count it
	logic [31:0] cnt_q;
	always_ff @(posedge clk) begin
		if (reset || !busy)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 32'h0000_0001;
	end
	property p_rst;
		$fell(reset) |-> !busy && !erase_pulse && io_oe == 4'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("not idle");
	property p_start;
		erase_pulse |-> busy && !$past(busy);
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_latch;
		$rose(busy) |-> write_latch_flag;
	endproperty
	a_latch: assert property (p_latch) else $error("no latch");
	property p_len;
		$fell(busy) |-> cnt_q == erase_cycles;
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_clr;
		$fell(busy) && !$past(wel_set) |-> !write_latch_flag;
	endproperty
	a_clr: assert property (p_clr) else $error("latch kept");
	property p_area;
		erase_pulse |-> erase_area != 2'h0 &&
			!area_lock_bits[erase_area - 2'h1];
	endproperty
	a_area: assert property (p_area) else $error("bad area");
	property p_lock;
		1'b1 |=> (area_lock_bits & $past(area_lock_bits | lock_set)) ==
			$past(area_lock_bits | lock_set);
	endproperty
	a_lock: assert property (p_lock) else $error("lock lost");
	property p_idle;
		cs_n [*8] |-> io_oe == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("lane driven");
	// only the idle, single, dual and quad lane patterns are legal
	property p_oe;
		io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'h3 || io_oe == 4'hF;
	endproperty
	a_oe: assert property (p_oe) else $error("bad lane enable");
	c_erase: cover property (erase_pulse);
	c_dual: cover property (io_oe == 4'h3);
	c_quad: cover property (io_oe == 4'hF);
endmodule // flash_id_props
bind flash_id_secreg flash_id_props #(.erase_cycles(erase_cycles))
	u_props (.clk(clk), .reset(reset), .cs_n(cs_n), .io_oe(io_oe),
	.wel_set(wel_set), .lock_set(lock_set),
	.write_latch_flag(write_latch_flag), .area_lock_bits(area_lock_bits),
	.busy(busy), .erase_pulse(erase_pulse), .erase_area(erase_area));
`default_nettype wire

// [verif/spi_host_model.sv]
// link host driving chip select, serial clock and data pins
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input wire logic clk,
	input wire logic [3:0] io_out,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_in
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_in = 4'h5;
	end
	// five system clocks per half period give the 80 ns link clock
	task automatic half(input logic lvl);
		repeat (5) @(posedge clk);
		sclk <= lvl;
	endtask
	// opcode on io0, nclk clocks of w lanes from tx, then nout read
	task automatic frame(input logic [7:0] op, input logic [47:0] tx,
		input int nclk, input int w, input int nout,
		output logic [63:0] rx);
		logic [47:0] sh;
		logic [3:0] v;
		sh = tx;
		rx = '0;
		v = 4'hF >> (4 - w);
		repeat (10) @(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < 8 + nclk + nout; i++) begin
			// data moves only while the clock is low
			if (i < 8)
				io_in <= {~io_in[3:1], op[7 - i]};
			else if (i < 8 + nclk) begin
				io_in <= ((sh[47:44] >> (4 - w)) & v) | (~io_in & ~v);
				sh = sh << w;
			end else
				io_in <= ~io_in;
			half(1'b1);
			if (i >= 8 + nclk)
				rx = (rx << w) | 64'(w == 1 ? {3'h0, io_out[1]} : io_out & v);
			half(1'b0);
		end
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		io_in <= ~io_in;
		@(posedge clk);
	endtask
endmodule // spi_host_model
`default_nettype wire

// [verif/tb_top.sv]
// bench for the identification and area erase decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int erase_n = 20;
	localparam logic [7:0] mfr = 8'hA5, dev = 8'h3C, mt = 8'h77, cap = 8'h18;
	localparam logic [63:0] uid = 64'h1357_9BDF_2468_ACE0; // arbitrary
	logic clk, reset, cs_n, sclk, wel_set, table_wr_en, write_latch_flag;
	logic busy, erase_pulse;
	logic [3:0] io_in, io_out, io_oe;
	logic [2:0] lock_set, area_lock_bits;
	logic [7:0] table_wr_addr, table_wr_data;
	logic [1:0] erase_area;
	logic [63:0] rx;
	logic [31:0] r;
	logic [7:0] tbl [256];
	logic [7:0] exp_q [$];
	int err_count = 0;
	int n_compared = 0;
	int seed = 32'hde5a7ee3;
	flash_id_secreg #(.erase_cycles(erase_n), .mfr_code(mfr),
		.device_code(dev), .mem_type(mt), .capacity(cap), .unique_id(uid))
		dut (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .wel_set(wel_set),
		.lock_set(lock_set), .table_wr_en(table_wr_en),
		.table_wr_addr(table_wr_addr), .table_wr_data(table_wr_data),
		.write_latch_flag(write_latch_flag), .area_lock_bits(area_lock_bits),
		.busy(busy), .erase_pulse(erase_pulse), .erase_area(erase_area));
	spi_host_model host (.clk(clk), .io_out(io_out), .cs_n(cs_n),
		.sclk(sclk), .io_in(io_in));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// model stream: queued bytes repeated for as long as clocks run
	function automatic logic [63:0] stream(input int nb);
		logic [63:0] e;
		e = '0;
		for (int i = 0; i < nb / 8; i++)
			e = (e << 8) | 64'(exp_q[i % exp_q.size()]);
		return e;
	endfunction
	task automatic rd(input logic [7:0] op, input logic [47:0] tx,
		input int nclk, input int w, input int nb);
		host.frame(op, tx, nclk, w, nb / w, rx);
		chk(rx, stream(nb));
	endtask
	task automatic set_latch;
		@(posedge clk);
		wel_set <= 1'b1;
		@(posedge clk);
		wel_set <= 1'b0;
	endtask
	task automatic er(input logic [23:0] a, input int extra, input logic ok);
		int n;
		n = 0;
		host.frame(8'h44, {a, 24'h0}, 24 + extra, 1, 0, rx);
		repeat (10) if (busy !== 1'b1) @(negedge clk);
		chk(busy, ok);
		if (ok) begin
			chk(erase_area, a[13:12]);
			while (busy === 1'b1 && n < 100) begin
				@(negedge clk);
				n++;
			end
			chk(n, erase_n);
			chk(write_latch_flag, 1'b0);
		end
	endtask
	initial begin
		reset = 1'b1;
		wel_set = 1'b0;
		lock_set = 3'h0;
		table_wr_en = 1'b0;
		table_wr_addr = 8'h00;
		table_wr_data = 8'h00;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 256; i++) begin
			@(posedge clk);
			r = $random(seed);
			tbl[i] = r[7:0];
			table_wr_en <= 1'b1;
			table_wr_addr <= 8'(i);
			table_wr_data <= r[7:0];
		end
		@(posedge clk);
		table_wr_en <= 1'b0;
		exp_q = {mfr, dev};
		rd(8'h90, 48'h0, 24, 1, 32);
		rd(8'h92, {24'h0, 4'hF, r[3:0], 16'h0}, 16, 2, 32);
		rd(8'h94, {r[31:16], 24'h0, 4'hF, r[7:4]}, 12, 4, 64);
		exp_q = {mfr, mt, cap};
		rd(8'h9F, 48'h0, 0, 1, 24);
		// an unknown opcode must leave the data lanes quiet
		host.frame(8'h3C, 48'h0, 0, 1, 16, rx);
		chk(rx, 64'h0000_0000_0000_0000);
		host.frame(8'h4B, {r, 16'h0}, 32, 1, 64, rx);
		chk(rx, uid);
		exp_q = {tbl[255], tbl[0], tbl[1]};
		rd(8'h5A, {16'h0, 8'hFF, r[7:0], 16'h0}, 32, 1, 24);
		er({12'h001, 4'h0, r[7:0]}, 0, 1'b0);
		set_latch;
		er({12'h004, 4'h0, r[7:0]}, 0, 1'b0);
		er({12'h101, 4'h0, r[7:0]}, 0, 1'b0);
		er({12'h002, 4'h0, r[7:0]}, 1, 1'b0);
		chk(write_latch_flag, 1'b1);
		for (int a = 1; a < 4; a++) begin
			set_latch;
			er({8'h00, 4'(a), 4'h0, r[15:8]}, 0, 1'b1);
		end
		@(posedge clk);
		lock_set <= 3'h2;
		@(posedge clk);
		lock_set <= 3'h0;
		set_latch;
		er({12'h002, 4'h0, r[7:0]}, 0, 1'b0);
		chk(area_lock_bits, 3'h2);
		er({12'h001, 4'h0, r[7:0]}, 0, 1'b1);
		tally_and_finish;
	end
	// the whole sequence needs under ten thousand clocks
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end
endmodule // tb_top
`default_nettype wire
